// ---- verilog/clock_gate_map.svh ----
`ifndef CLOCK_GATE_MAP_SVH
`define CLOCK_GATE_MAP_SVH

// ****************************************
// register offsets from the control base
// ****************************************
`define CG_BASE_ADDR        32'h400FE000
`define CG_OFF_RUN_CFG      12'h060
`define CG_OFF_RUN_ZERO     12'h100
`define CG_OFF_RUN_ONE      12'h104
`define CG_OFF_SLEEP_ZERO   12'h110
`define CG_OFF_SLEEP_ONE    12'h114
`define CG_OFF_DEEP_ZERO    12'h120
`define CG_OFF_DEEP_ONE     12'h124
`define CG_OFF_IRQ_STATUS   12'h130
`define CG_OFF_IRQ_MASK     12'h134

// ****************************************
// field positions
// ****************************************
`define CG_BIT_PWM          20
`define CG_BIT_CONVERTER    16
`define CG_RATE_LSB         8
`define CG_RATE_MSB         11
`define CG_BIT_WATCHDOG     3
`define CG_BIT_COUNTER0     16
`define CG_BIT_SYNC0        4
`define CG_BIT_SER1         1
`define CG_BIT_SER0         0
`define CG_BIT_AUTO_GATE    27
`define CG_IRQ_FAULT        0
`define CG_IRQ_CLAMP        1
`define CG_IRQ_MODE         2

// ****************************************
// writable masks and reset values
// ****************************************
`define CG_MASK_ZERO        32'h00110F08
`define CG_MASK_ONE         32'h00010013
`define CG_MASK_RUN_CFG     32'h08000000
`define CG_MASK_IRQ         32'h00000007
`define CG_RESET_VALUE      32'h00000000

// ****************************************
// converter rate codes and timing
// ****************************************
`define CG_RATE_CODE_500K   4'h2
`define CG_RATE_CODE_250K   4'h1
`define CG_RATE_CODE_125K   4'h0
`define CG_RATE_CODE_MAX    4'h2
`define CG_CLK_KHZ          250000
`define CG_RATE_500_KSPS    500
`define CG_RATE_250_KSPS    250
`define CG_RATE_125_KSPS    125
`define CG_PERIOD_500K      (`CG_CLK_KHZ / `CG_RATE_500_KSPS)
`define CG_PERIOD_250K      (`CG_CLK_KHZ / `CG_RATE_250_KSPS)
`define CG_PERIOD_125K      (`CG_CLK_KHZ / `CG_RATE_125_KSPS)

`endif

// ---- verilog/clock_gate_pkg.sv ----
package clock_gate_pkg;

    // ****************************************
    // operating modes
    // ****************************************
    typedef enum logic [1:0] {
        MODE_RUN   = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_DEEP  = 2'b10
    } power_mode_t;

    // ****************************************
    // gated unit identifiers
    // ****************************************
    typedef enum logic [2:0] {
        UNIT_WATCHDOG  = 3'b000,
        UNIT_CONVERTER = 3'b001,
        UNIT_PWM       = 3'b010,
        UNIT_COUNTER0  = 3'b011,
        UNIT_SYNC0     = 3'b100,
        UNIT_SER1      = 3'b101,
        UNIT_SER0      = 3'b110
    } unit_id_t;

    // ****************************************
    // one gating set: register zero and one
    // ****************************************
    typedef struct packed {
        logic [31:0] zero;
        logic [31:0] one;
    } gate_set_t;

    // ****************************************
    // per-unit clock enables
    // ****************************************
    typedef struct packed {
        logic pwm;
        logic converter;
        logic watchdog;
        logic counter0;
        logic sync0;
        logic ser1;
        logic ser0;
    } periph_en_t;

endpackage

// ---- verilog/gate_select.sv ----
`timescale 1ns/1ns
`default_nettype none

module gate_select
    import clock_gate_pkg::*;
(
    // gating sets
    input  wire gate_set_t   run_set,
    input  wire gate_set_t   sleep_set,
    input  wire gate_set_t   deep_set,
    // mode
    input  wire power_mode_t mode,
    input  wire logic        auto_gate,
    // selected set
    output logic [63:0]      active
);

    wire [63:0] run_bits   = run_set;
    wire [63:0] sleep_bits = sleep_set;
    wire [63:0] deep_bits  = deep_set;
    wire        use_sleep  = auto_gate && (mode == MODE_SLEEP);
    wire        use_deep   = auto_gate && (mode == MODE_DEEP);

    // ****************************************
    // per-bit selection of the active set
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < 64; i = i + 1) begin : g_bit
            assign active[i] = use_deep  ? deep_bits[i]  :
                               use_sleep ? sleep_bits[i] :
                                           run_bits[i];
        end
    endgenerate

endmodule

`default_nettype wire

// ---- verilog/peripheral_clock_gating.sv ----
// Behaviour
// - rate code 0x2 is 500K, 0x1 is 250K, 0x0 is 125K samples/s.
// - converter never runs above its maximum rate, whatever is written.
// - watchdog clocked while gate bit 3 is one, held disabled otherwise.
// - any access to an unclocked unit answers with a bus fault.
// - every gate bit resets to zero, all units start unclocked.
// - separate run, sleep and deep-sleep gating sets.
// - sleep sets apply only when automatic gating bit is set.
// - run gating register one sits at offset 0x104.
// - counter module zero clocked from bit 16 of gating register one.
// - sync serial module zero clocked from bit 4 of gating register one.
// - serial ports one and zero clocked from bits 1 and 0.
// - reserved bits read zero and ignore writes.
// - pulse-width unit clocked from bit 20 of gating register zero.
// - sleep gating register one at offset 0x114, same layout.
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "clock_gate_map.svh"

module peripheral_clock_gating
    import clock_gate_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // power mode requests
    input  wire logic        sleep_req,
    input  wire logic        deep_sleep_req,
    output var power_mode_t  power_mode,
    // gated unit access check
    input  wire logic        unit_req,
    input  wire unit_id_t    unit_sel,
    output logic             unit_fault,
    output logic             unit_ok,
    // clock enables
    output var periph_en_t   periph_en,
    output logic             watchdog_hold,
    // converter rate
    output logic [1:0]       converter_rate_sel,
    output logic             converter_sample_tick,
    // interrupt
    output logic             irq
);

    // ****************************************
    // state
    // ****************************************
    gate_set_t   run_set_reg;
    gate_set_t   run_set_next;
    gate_set_t   sleep_set_reg;
    gate_set_t   sleep_set_next;
    gate_set_t   deep_set_reg;
    gate_set_t   deep_set_next;
    logic [31:0] run_cfg_reg;
    logic [31:0] run_cfg_next;
    logic [31:0] irq_status_reg;
    logic [31:0] irq_status_next;
    logic [31:0] irq_mask_reg;
    logic [31:0] irq_mask_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        rd_err_reg;
    logic        rd_err_next;
    power_mode_t mode_reg;
    power_mode_t mode_next;
    periph_en_t  en_reg;
    periph_en_t  en_next;
    logic [10:0] tick_cnt_reg;
    logic [10:0] tick_cnt_next;
    logic        tick_reg;
    logic        tick_next;
    logic [63:0] active_bits;

    // ****************************************
    // apb phases and byte lanes
    // ****************************************
    wire        setup_phase = psel && !penable;
    wire        access      = psel && penable;
    wire        wr_go       = access && pwrite;
    wire [31:0] lane_mask   = {{8{pstrb[3]}}, {8{pstrb[2]}},
                               {8{pstrb[1]}}, {8{pstrb[0]}}};

    // ****************************************
    // address decode
    // ****************************************
    wire hit_run_cfg    = (paddr == `CG_OFF_RUN_CFG);
    wire hit_run_zero   = (paddr == `CG_OFF_RUN_ZERO);
    wire hit_run_one    = (paddr == `CG_OFF_RUN_ONE);
    wire hit_sleep_zero = (paddr == `CG_OFF_SLEEP_ZERO);
    wire hit_sleep_one  = (paddr == `CG_OFF_SLEEP_ONE);
    wire hit_deep_zero  = (paddr == `CG_OFF_DEEP_ZERO);
    wire hit_deep_one   = (paddr == `CG_OFF_DEEP_ONE);
    wire hit_status     = (paddr == `CG_OFF_IRQ_STATUS);
    wire hit_mask       = (paddr == `CG_OFF_IRQ_MASK);
    wire hit_any        = hit_run_cfg | hit_run_zero | hit_run_one |
                          hit_sleep_zero | hit_sleep_one |
                          hit_deep_zero | hit_deep_one |
                          hit_status | hit_mask;

    // ****************************************
    // write data merge
    // ****************************************
    // reserved bits ignore writes
    wire [31:0] wr_zero_mask = lane_mask & `CG_MASK_ZERO;
    wire [31:0] wr_one_mask  = lane_mask & `CG_MASK_ONE;
    wire [31:0] wr_cfg_mask  = lane_mask & `CG_MASK_RUN_CFG;
    wire [31:0] wr_irq_mask  = lane_mask & `CG_MASK_IRQ;

    wire [3:0]  wr_rate     = pwdata[`CG_RATE_MSB:`CG_RATE_LSB];
    wire        rate_over   = wr_rate > `CG_RATE_CODE_MAX;
    wire [3:0]  wr_rate_lim = rate_over ? `CG_RATE_CODE_MAX : wr_rate;
    wire [31:0] wdata_zero  = {pwdata[31:`CG_RATE_MSB+1], wr_rate_lim,
                               pwdata[`CG_RATE_LSB-1:0]};

    function automatic logic [31:0] merge(input logic [31:0] old_val,
                                          input logic [31:0] new_val,
                                          input logic [31:0] mask);
        merge = (old_val & ~mask) | (new_val & mask);
    endfunction

    wire wr_run_zero   = wr_go && hit_run_zero;
    wire wr_run_one    = wr_go && hit_run_one;
    wire wr_sleep_zero = wr_go && hit_sleep_zero;
    wire wr_sleep_one  = wr_go && hit_sleep_one;
    wire wr_deep_zero  = wr_go && hit_deep_zero;
    wire wr_deep_one   = wr_go && hit_deep_one;
    wire wr_run_cfg    = wr_go && hit_run_cfg;
    wire wr_status     = wr_go && hit_status;
    wire wr_mask       = wr_go && hit_mask;
    wire zero_wr_any   = wr_run_zero | wr_sleep_zero | wr_deep_zero;
    wire clamp_event   = zero_wr_any && rate_over && pstrb[1];

    // ****************************************
    // gating set next values
    // ****************************************
    // three independent sets
    always_comb begin
        run_set_next   = run_set_reg;
        sleep_set_next = sleep_set_reg;
        deep_set_next  = deep_set_reg;
        if (wr_run_zero) begin
            run_set_next.zero = merge(run_set_reg.zero, wdata_zero,
                                      wr_zero_mask);
        end
        if (wr_run_one) begin
            run_set_next.one = merge(run_set_reg.one, pwdata,
                                     wr_one_mask);
        end
        if (wr_sleep_zero) begin
            sleep_set_next.zero = merge(sleep_set_reg.zero, wdata_zero,
                                        wr_zero_mask);
        end
        if (wr_sleep_one) begin
            sleep_set_next.one = merge(sleep_set_reg.one, pwdata,
                                       wr_one_mask);
        end
        if (wr_deep_zero) begin
            deep_set_next.zero = merge(deep_set_reg.zero, wdata_zero,
                                       wr_zero_mask);
        end
        if (wr_deep_one) begin
            deep_set_next.one = merge(deep_set_reg.one, pwdata,
                                      wr_one_mask);
        end
    end

    assign run_cfg_next = wr_run_cfg ?
                          merge(run_cfg_reg, pwdata, wr_cfg_mask) :
                          run_cfg_reg;
    assign irq_mask_next = wr_mask ?
                           merge(irq_mask_reg, pwdata, wr_irq_mask) :
                           irq_mask_reg;

    // ****************************************
    // power mode tracking
    // ****************************************
    always_comb begin
        unique case (mode_reg)
            MODE_RUN, MODE_SLEEP, MODE_DEEP: begin
                if (deep_sleep_req) begin
                    mode_next = MODE_DEEP;
                end else if (sleep_req) begin
                    mode_next = MODE_SLEEP;
                end else begin
                    mode_next = MODE_RUN;
                end
            end
            default: begin
                mode_next = MODE_RUN;
            end
        endcase
    end

    wire mode_event = (mode_next != mode_reg);

    // ****************************************
    // active set selection
    // ****************************************
    gate_select u_gate_select (
        .run_set   (run_set_reg),
        .sleep_set (sleep_set_reg),
        .deep_set  (deep_set_reg),
        .mode      (mode_reg),
        .auto_gate (run_cfg_reg[`CG_BIT_AUTO_GATE]),
        .active    (active_bits)
    );

    wire [31:0] act_zero = active_bits[63:32];
    wire [31:0] act_one  = active_bits[31:0];

    // ****************************************
    // unit clock enables
    // ****************************************
    always_comb begin
        en_next.pwm       = act_zero[`CG_BIT_PWM];
        en_next.converter = act_zero[`CG_BIT_CONVERTER];
        en_next.watchdog  = act_zero[`CG_BIT_WATCHDOG];
        en_next.counter0  = act_one[`CG_BIT_COUNTER0];
        en_next.sync0     = act_one[`CG_BIT_SYNC0];
        en_next.ser1      = act_one[`CG_BIT_SER1];
        en_next.ser0      = act_one[`CG_BIT_SER0];
    end

    assign periph_en     = en_reg;
    assign watchdog_hold = !en_reg.watchdog;

    // ****************************************
    // access check toward gated units
    // ****************************************
    logic unit_clocked;
    always_comb begin
        unique case (unit_sel)
            UNIT_WATCHDOG:  unit_clocked = en_reg.watchdog;
            UNIT_CONVERTER: unit_clocked = en_reg.converter;
            UNIT_PWM:       unit_clocked = en_reg.pwm;
            UNIT_COUNTER0:  unit_clocked = en_reg.counter0;
            UNIT_SYNC0:     unit_clocked = en_reg.sync0;
            UNIT_SER1:      unit_clocked = en_reg.ser1;
            UNIT_SER0:      unit_clocked = en_reg.ser0;
            default:        unit_clocked = 1'b0;
        endcase
    end

    assign unit_fault = unit_req && !unit_clocked;
    assign unit_ok    = unit_req && unit_clocked;

    // ****************************************
    // converter rate decode and sample tick
    // ****************************************
    wire [3:0] rate_code = act_zero[`CG_RATE_MSB:`CG_RATE_LSB];
    logic [10:0] rate_period;
    always_comb begin
        unique case (rate_code)
            `CG_RATE_CODE_500K: begin
                rate_period        = 11'(`CG_PERIOD_500K);
                converter_rate_sel = 2'h2;
            end
            `CG_RATE_CODE_250K: begin
                rate_period        = 11'(`CG_PERIOD_250K);
                converter_rate_sel = 2'h1;
            end
            `CG_RATE_CODE_125K: begin
                rate_period        = 11'(`CG_PERIOD_125K);
                converter_rate_sel = 2'h0;
            end
            // any other code runs at most
            default: begin
                rate_period        = 11'(`CG_PERIOD_500K);
                converter_rate_sel = 2'h2;
            end
        endcase
    end

    wire tick_wrap = (tick_cnt_reg >= rate_period - 11'h001);
    always_comb begin
        if (!en_reg.converter) begin
            tick_cnt_next = 11'h000;
            tick_next     = 1'b0;
        end else if (tick_wrap) begin
            tick_cnt_next = 11'h000;
            tick_next     = 1'b1;
        end else begin
            tick_cnt_next = tick_cnt_reg + 11'h001;
            tick_next     = 1'b0;
        end
    end

    assign converter_sample_tick = tick_reg;

    // ****************************************
    // interrupt status, set wins over clear
    // ****************************************
    wire [31:0] irq_set = {29'h0, mode_event, clamp_event, unit_fault};
    wire [31:0] irq_clr = wr_status ? (pwdata & wr_irq_mask) : 32'h0;
    assign irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;
    assign irq = |(irq_status_reg & irq_mask_reg);

    // ****************************************
    // read data, loaded in setup phase
    // ****************************************
    // reserved bits read zero
    wire [31:0] rd_mux =
        hit_run_cfg    ? (run_cfg_reg & `CG_MASK_RUN_CFG)      :
        hit_run_zero   ? (run_set_reg.zero & `CG_MASK_ZERO)    :
        hit_run_one    ? (run_set_reg.one & `CG_MASK_ONE)      :
        hit_sleep_zero ? (sleep_set_reg.zero & `CG_MASK_ZERO)  :
        hit_sleep_one  ? (sleep_set_reg.one & `CG_MASK_ONE)    :
        hit_deep_zero  ? (deep_set_reg.zero & `CG_MASK_ZERO)   :
        hit_deep_one   ? (deep_set_reg.one & `CG_MASK_ONE)     :
        hit_status     ? (irq_status_reg & `CG_MASK_IRQ)       :
        hit_mask       ? (irq_mask_reg & `CG_MASK_IRQ)         :
                         32'h00000000;

    assign prdata_next = setup_phase ? rd_mux : prdata_reg;
    assign rd_err_next = setup_phase ? !hit_any : rd_err_reg;

    assign pready  = 1'b1;
    assign pslverr = access && rd_err_reg;
    assign prdata  = prdata_reg;

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            run_set_reg   <= '{zero: `CG_RESET_VALUE, one: `CG_RESET_VALUE};
            sleep_set_reg <= '{zero: `CG_RESET_VALUE, one: `CG_RESET_VALUE};
            deep_set_reg  <= '{zero: `CG_RESET_VALUE, one: `CG_RESET_VALUE};
            run_cfg_reg   <= `CG_RESET_VALUE;
        end else begin
            run_set_reg   <= run_set_next;
            sleep_set_reg <= sleep_set_next;
            deep_set_reg  <= deep_set_next;
            run_cfg_reg   <= run_cfg_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_status_reg <= `CG_RESET_VALUE;
            irq_mask_reg   <= `CG_RESET_VALUE;
            prdata_reg     <= `CG_RESET_VALUE;
            rd_err_reg     <= 1'b0;
        end else begin
            irq_status_reg <= irq_status_next;
            irq_mask_reg   <= irq_mask_next;
            prdata_reg     <= prdata_next;
            rd_err_reg     <= rd_err_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg     <= MODE_RUN;
            en_reg       <= '0;
            tick_cnt_reg <= 11'h000;
            tick_reg     <= 1'b0;
        end else begin
            mode_reg     <= mode_next;
            en_reg       <= en_next;
            tick_cnt_reg <= tick_cnt_next;
            tick_reg     <= tick_next;
        end
    end

    assign power_mode = mode_reg;

endmodule

`default_nettype wire

// ---- verif/unit_access_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module unit_access_model
    import clock_gate_pkg::*;
(
    // clock and command
    input  wire logic     clk,
    input  wire logic     go,
    input  wire unit_id_t id,
    // access toward the block
    output logic          unit_req,
    output var unit_id_t  unit_sel
);
    logic [2:0] spin = 3'h0;

    always @(posedge clk) begin
        unit_req <= go;
        spin     <= spin + 3'h1;
        unit_sel <= go ? id : unit_id_t'(spin);
    end
endmodule

`default_nettype wire

// ---- verif/pcg_chk.sv ----
`timescale 1ns/1ns
`default_nettype none

module pcg_chk
    import clock_gate_pkg::*;
(
    // clock, reset, bus
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    // unit access and enables
    input wire logic        unit_req,
    input wire unit_id_t    unit_sel,
    input wire logic        unit_fault,
    input wire logic        unit_ok,
    input wire periph_en_t  periph_en,
    input wire logic        watchdog_hold,
    input wire power_mode_t power_mode,
    // converter and interrupt
    input wire logic [1:0]  converter_rate_sel,
    input wire logic        converter_sample_tick,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_hold_gate: assert property (
        watchdog_hold == !periph_en.watchdog) else $error("hold wrong");
    a_wdog_fault: assert property (
        unit_req && unit_sel == UNIT_WATCHDOG |->
        unit_fault == !periph_en.watchdog) else $error("wdog fault");
    a_sync_gate: assert property (
        unit_req && unit_sel == UNIT_SYNC0 |-> unit_ok == periph_en.sync0)
        else $error("sync gate");
    a_ser_gate: assert property (
        unit_req && unit_sel == UNIT_SER1 |-> unit_ok == periph_en.ser1)
        else $error("ser gate");
    a_unit_excl: assert property (
        (unit_fault || unit_ok) == unit_req && !(unit_fault && unit_ok))
        else $error("unit answer");
    a_rate_max: assert property (
        converter_rate_sel <= 2'h2) else $error("rate too high");
    a_tick_gap: assert property (
        $rose(converter_sample_tick) |=> !converter_sample_tick [*8])
        else $error("tick gap");
    a_reset_off: assert property (disable iff (1'b0)
        rst |=> periph_en == 7'h00 && !irq) else $error("reset");
    a_en_cause: assert property (
        $changed(periph_en) |-> $past(psel && penable && pwrite, 2) ||
        $past(power_mode) != $past(power_mode, 2)) else $error("en cause");
endmodule

bind peripheral_clock_gating pcg_chk u_chk (.clk, .rst, .psel, .penable,
    .pwrite, .unit_req, .unit_sel, .unit_fault, .unit_ok, .periph_en,
    .watchdog_hold, .power_mode, .converter_rate_sel,
    .converter_sample_tick, .irq);

`default_nettype wire

// ---- verif/peripheral_clock_gating_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "clock_gate_map.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module peripheral_clock_gating_tb_top
    import clock_gate_pkg::*;
;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdat;
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr, perr, unit_req, unit_fault, unit_ok;
    logic        sleep_req = 0, deep_sleep_req = 0, go = 0;
    logic        watchdog_hold, converter_sample_tick, irq;
    logic [1:0]  converter_rate_sel;
    logic [6:0]  e;
    power_mode_t power_mode;
    unit_id_t    unit_sel, uid = UNIT_WATCHDOG;
    periph_en_t  periph_en;
    int          errors = 0, n_tests = 0;
    logic [31:0] mdl [4096] = '{default: 32'h0};
    int          bitof [7] = '{4, 5, 6, 3, 2, 1, 0};
    int          offs [8] = '{'h60, 'h100, 'h104, 'h110, 'h114, 'h120,
                              'h124, 'h134};

    always #2 clk = ~clk;

    peripheral_clock_gating dut (.clk, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .pready, .pslverr, .prdata, .sleep_req,
        .deep_sleep_req, .power_mode, .unit_req, .unit_sel, .unit_fault,
        .unit_ok, .periph_en, .watchdog_hold, .converter_rate_sel,
        .converter_sample_tick, .irq);
    unit_access_model far (.clk, .go, .id(uid), .unit_req, .unit_sel);

    task automatic stop_test;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int i;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            errors++;
            stop_test();
        end
        rdat = prdata;
        perr = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clk);
    endtask

    // register model with masks and rate clamp
    function automatic logic [31:0] fix(logic [11:0] a, logic [31:0] d);
        logic [31:0] v;
        v = 32'h0;
        case (a)
            `CG_OFF_RUN_ZERO, `CG_OFF_SLEEP_ZERO, `CG_OFF_DEEP_ZERO: begin
                v = d & `CG_MASK_ZERO;
                if (v[11:8] > 4'h2) v[11:8] = 4'h2;
            end
            `CG_OFF_RUN_ONE, `CG_OFF_SLEEP_ONE, `CG_OFF_DEEP_ONE:
                v = d & `CG_MASK_ONE;
            `CG_OFF_RUN_CFG: v = d & `CG_MASK_RUN_CFG;
            `CG_OFF_IRQ_MASK: v = d & `CG_MASK_IRQ;
            default: v = 32'h0;
        endcase
        return v;
    endfunction

    function automatic logic [11:0] set_base();
        logic auto_on;
        auto_on = mdl[`CG_OFF_RUN_CFG][`CG_BIT_AUTO_GATE];
        if (auto_on && deep_sleep_req) return `CG_OFF_DEEP_ZERO;
        if (auto_on && sleep_req) return `CG_OFF_SLEEP_ZERO;
        return `CG_OFF_RUN_ZERO;
    endfunction

    function automatic logic [6:0] en_exp();
        logic [11:0] b;
        b = set_base();
        return {mdl[b][20], mdl[b][16], mdl[b][3], mdl[b + 4][16],
                mdl[b + 4][4], mdl[b + 4][1], mdl[b + 4][0]};
    endfunction

    task automatic wr(logic [11:0] a, logic [31:0] d);
        apb(1, a, d);
        mdl[a] = fix(a, d);
    endtask

    task automatic rd(logic [11:0] a);
        apb(0, a, 32'h0);
        `CHK("read", mdl[a], rdat)
    endtask

    initial begin
        int i, k, cnt;
        logic [31:0] d;
        void'($urandom(32'hA9678E2C));
        repeat (16) @(posedge clk);
        rst <= 0;
        `CHK("hold", 1'b1, watchdog_hold)
        for (i = 0; i < 8; i++) rd(offs[i][11:0]);
        for (i = 0; i < 16; i++) begin
            d = $urandom;
            d[11:8] = i[3:0];
            wr(`CG_OFF_RUN_ZERO, d);
            wr(`CG_OFF_RUN_ONE, $urandom);
            rd(`CG_OFF_RUN_ZERO);
            rd(`CG_OFF_RUN_ONE);
            `CHK("en", en_exp(), periph_en)
            `CHK("rate", mdl[`CG_OFF_RUN_ZERO][9:8], converter_rate_sel)
        end
        for (k = 2; k >= 0; k--) begin
            wr(`CG_OFF_RUN_ZERO, 32'h00010000 | (k << 8));
            repeat (500 << (2 - k)) @(posedge clk);
            cnt = 0;
            repeat (1000 << (2 - k)) begin
                @(posedge clk);
                cnt += converter_sample_tick;
            end
            `CHK("ticks", 2, cnt)
        end
        wr(`CG_OFF_RUN_ZERO, $urandom | 32'h00000F00);
        wr(`CG_OFF_RUN_ONE, $urandom);
        apb(0, `CG_OFF_IRQ_STATUS, 32'h0);
        `CHK("clamp", 1'b1, rdat[1])
        wr(`CG_OFF_IRQ_STATUS, 32'h7);
        for (i = 0; i < 7; i++) begin
            wr(`CG_OFF_IRQ_MASK, i & 1);
            e = en_exp();
            uid <= unit_id_t'(i);
            go <= 1;
            @(posedge clk);
            go <= 0;
            @(negedge clk);
            `CHK("fault", !e[bitof[i]], unit_fault)
            `CHK("ok", e[bitof[i]], unit_ok)
            @(negedge clk);
            `CHK("irq", !e[bitof[i]] & i[0], irq)
            @(posedge clk);
            apb(0, `CG_OFF_IRQ_STATUS, 32'h0);
            `CHK("status", !e[bitof[i]], rdat[0])
            wr(`CG_OFF_IRQ_STATUS, 32'h1);
        end
        for (i = 0; i < 4; i++) wr(12'h110 + 16 * i[1] + 4 * i[0], $urandom);
        rd(`CG_OFF_SLEEP_ONE);
        for (i = 0; i < 8; i++) begin
            sleep_req <= i[0];
            deep_sleep_req <= i[1];
            wr(`CG_OFF_RUN_CFG, {4'h0, i[2], 27'h0});
            @(posedge clk);
            `CHK("en", en_exp(), periph_en)
            `CHK("mode", i[1] ? MODE_DEEP : i[0] ? MODE_SLEEP : MODE_RUN,
                 power_mode)
        end
        apb(0, `CG_OFF_IRQ_STATUS, 32'h0);
        `CHK("mode evt", 1'b1, rdat[2])
        apb(0, 12'h008, 32'h0);
        `CHK("slverr", 1'b1, perr)
        stop_test();
    end
endmodule

`default_nettype wire
